// file: verilog/sfm_regs.svh
// Offsets, field positions and reset values of the status and memory map block
`ifndef SFM_REGS_SVH
`define SFM_REGS_SVH
`define SFM_STATUS_OFS 7'h03
`define SFM_CORE_LAST 7'h0B
`define SFM_SFR_FIRST 7'h0C
`define SFM_SFR_LAST 7'h1F
`define SFM_GPR_FIRST 7'h20
`define SFM_GPR_LAST 7'h6F
`define SFM_COM_FIRST 7'h70
`define SFM_COM_LAST 7'h7F
`define SFM_GPR_BYTES 80
`define SFM_COM_BYTES 16
`define SFM_BANK_MSB 11
`define SFM_BANK_LSB 7
`define SFM_OFS_MSB 6
`define SFM_BIT_TO 4
`define SFM_BIT_PD 3
`define SFM_BIT_Z 2
`define SFM_BIT_DC 1
`define SFM_BIT_C 0
`define SFM_CAUSE_POR 1'b1
`define SFM_ARITH_POR 1'b0
`define SFM_UNUSED_HI 3'h0
`endif

// file: verilog/sfm_pkg.sv
// Types shared by the status and memory map block
package sfm_pkg;
   typedef logic [7:0] sfm_byte_t;
   typedef logic [11:0] sfm_addr_t;
   typedef enum logic [4:0] {
      SFM_OP_ADD_W_FILE = 5'h01,
      SFM_OP_ADD_LITERAL = 5'h02,
      SFM_OP_LITERAL_SUB = 5'h04,
      SFM_OP_SUB_W_FILE = 5'h08,
      SFM_OP_LOGIC = 5'h10
   } sfm_op_e;
endpackage

// file: verilog/sfm_ram_if.sv
// Port bundle between the map decoder and the RAM array
`timescale 1ns/1ns
interface sfm_ram_if #(
   parameter int AW = 10
);
   logic we;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: verilog/sfm_ram.sv
// Byte RAM holding banked general RAM and common RAM, registered read
`timescale 1ns/1ns
module sfm_ram import sfm_pkg::*; #(
   parameter int DEPTH = 656,
   parameter int AW = 10
) (
   input wire logic clk,
   sfm_ram_if.mem port
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rdata_q;

   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
      $error("sfm_ram depth does not fit address width");
   end

   always_ff @(posedge clk) begin
      if (port.we && (int'(port.addr) < DEPTH)) begin
         mem_q[port.addr] <= port.wdata;
      end
      rdata_q <= (int'(port.addr) < DEPTH) ? mem_q[port.addr] : 8'h00;
   end

   assign port.rdata = rdata_q;
endmodule

// file: verilog/sfm_core_data.sv
// Status flags register and banked data memory map
`timescale 1ns/1ns
`include "sfm_regs.svh"

module sfm_core_data import sfm_pkg::*; #(
   parameter int GPR_BANKS = 8
) (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic POR_RESET_N,
   input wire logic EXEC_VALID,
   input wire logic [4:0] EXEC_KIND,
   input wire logic [7:0] OPND_A,
   input wire logic [7:0] OPND_B,
   input wire logic [7:0] LOGIC_RESULT,
   input wire logic WATCHDOG_KICK_OP,
   input wire logic SLEEP_OP,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic [11:0] DATA_ADDR,
   input wire logic LINEAR_ACCESS,
   input wire logic DATA_WE,
   input wire logic DATA_RE,
   input wire logic [7:0] DATA_WDATA,
   output logic [7:0] DATA_RDATA,
   output logic CORE_REG_HIT,
   output logic PERIPH_HIT,
   output logic [7:0] ALU_RESULT,
   output logic [7:0] STATUS_FLAGS
);
   localparam int RAM_DEPTH = GPR_BANKS * `SFM_GPR_BYTES + `SFM_COM_BYTES;
   localparam int RAM_AW = $clog2(RAM_DEPTH);
   localparam int COM_BASE = GPR_BANKS * `SFM_GPR_BYTES;
   localparam int BANK_COUNT = 1 << (`SFM_BANK_MSB - `SFM_BANK_LSB + 1);

   // Bank field is five bits wide; more banks cannot be addressed
   if (GPR_BANKS < 1 || GPR_BANKS > BANK_COUNT) begin : g_bad_banks
      $error("GPR_BANKS must lie between 1 and 32");
   end

   // Reset release synchronisers; assertion stays asynchronous
   logic [1:0] rst_sync_q;
   logic [1:0] rst_sync_d;
   logic [1:0] por_sync_q;
   logic [1:0] por_sync_d;
   logic rst_n;
   logic por_n;

   always_comb begin
      rst_sync_d = {rst_sync_q[0], 1'b1};
      por_sync_d = {por_sync_q[0], 1'b1};
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= rst_sync_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge POR_RESET_N) begin
      if (!POR_RESET_N) begin
         por_sync_q <= 2'h0;
      end else begin
         por_sync_q <= por_sync_d;
      end
   end

   assign rst_n = rst_sync_q[1];
   assign por_n = por_sync_q[1];

   // Adder with carry-in; returns {carry, nibble carry, sum}
   function automatic logic [9:0] sfm_add(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      return {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   // Arithmetic decode
   logic is_arith;
   logic is_sub;
   logic affects_flags;
   logic [9:0] sum;

   always_comb begin
      is_arith = 1'b0;
      is_sub = 1'b0;
      affects_flags = 1'b0;
      if (EXEC_VALID) begin
         unique case (EXEC_KIND)
            SFM_OP_ADD_W_FILE, SFM_OP_ADD_LITERAL: begin
               is_arith = 1'b1;
               affects_flags = 1'b1;
            end
            SFM_OP_LITERAL_SUB, SFM_OP_SUB_W_FILE: begin
               is_arith = 1'b1;
               is_sub = 1'b1;
               affects_flags = 1'b1;
            end
            SFM_OP_LOGIC: begin
               affects_flags = 1'b1;
            end
            default: begin
               affects_flags = 1'b0;
            end
         endcase
      end
   end

   // Subtraction adds the two's complement of the second operand
   logic [7:0] addend;
   assign addend = is_sub ? ~OPND_B : OPND_B;
   assign sum = sfm_add(OPND_A, addend, is_sub);

   // Address decode
   logic [4:0] bank;
   logic [6:0] ofs;
   logic status_hit;
   logic ram_hit;
   logic [RAM_AW-1:0] ram_addr;

   always_comb begin
      bank = DATA_ADDR[`SFM_BANK_MSB:`SFM_BANK_LSB];
      ofs = DATA_ADDR[`SFM_OFS_MSB:0];
      status_hit = 1'b0;
      ram_hit = 1'b0;
      ram_addr = '0;
      CORE_REG_HIT = 1'b0;
      PERIPH_HIT = 1'b0;
      if (LINEAR_ACCESS) begin
         if (int'(DATA_ADDR) < COM_BASE) begin
            ram_hit = 1'b1;
            ram_addr = RAM_AW'(DATA_ADDR);
         end
      end else if (ofs <= `SFM_CORE_LAST) begin
         CORE_REG_HIT = 1'b1;
         status_hit = (ofs == `SFM_STATUS_OFS);
      end else if (ofs <= `SFM_SFR_LAST) begin
         PERIPH_HIT = 1'b1;
      end else if (ofs <= `SFM_GPR_LAST) begin
         // Banks at or above GPR_BANKS have no general RAM and read zero
         if (int'(bank) < GPR_BANKS) begin
            ram_hit = 1'b1;
            ram_addr = RAM_AW'(int'(bank) * `SFM_GPR_BYTES
                                + int'(ofs - `SFM_GPR_FIRST));
         end
      end else begin
         ram_hit = 1'b1;
         ram_addr = RAM_AW'(COM_BASE + int'(ofs - `SFM_COM_FIRST));
      end
   end

   // Status flags
   logic wdt_n_q;
   logic wdt_n_d;
   logic slp_n_q;
   logic slp_n_d;
   logic z_q;
   logic z_d;
   logic dc_q;
   logic dc_d;
   logic c_q;
   logic c_d;

   always_comb begin
      wdt_n_d = wdt_n_q;
      slp_n_d = slp_n_q;
      z_d = z_q;
      dc_d = dc_q;
      c_d = c_q;
      if (WATCHDOG_KICK_OP) begin
         wdt_n_d = 1'b1;
         slp_n_d = 1'b1;
      end
      if (SLEEP_OP) begin
         wdt_n_d = 1'b1;
         slp_n_d = 1'b0;
      end
      // Timeout overrides a kick in the same cycle
      if (WATCHDOG_TIMEOUT) begin
         wdt_n_d = 1'b0;
      end
      // Cause flags have no write path at all
      if (DATA_WE && status_hit && !affects_flags) begin
         z_d = DATA_WDATA[`SFM_BIT_Z];
         dc_d = DATA_WDATA[`SFM_BIT_DC];
         c_d = DATA_WDATA[`SFM_BIT_C];
      end
      if (is_arith) begin
         z_d = (sum[7:0] == 8'h00);
         dc_d = sum[8];
         c_d = sum[9];
      end else if (affects_flags) begin
         z_d = (LOGIC_RESULT == 8'h00);
      end
   end

   // Only power-on or brown-out resets the flags; other resets keep them
   // so that software can still read why the core restarted
   always_ff @(posedge CLK_SYS or negedge por_n) begin
      if (!por_n) begin
         wdt_n_q <= `SFM_CAUSE_POR;
         slp_n_q <= `SFM_CAUSE_POR;
         z_q <= `SFM_ARITH_POR;
         dc_q <= `SFM_ARITH_POR;
         c_q <= `SFM_ARITH_POR;
      end else begin
         wdt_n_q <= wdt_n_d;
         slp_n_q <= slp_n_d;
         z_q <= z_d;
         dc_q <= dc_d;
         c_q <= c_d;
      end
   end

   logic [7:0] status_word;
   assign status_word = {`SFM_UNUSED_HI, wdt_n_q, slp_n_q, z_q, dc_q, c_q};
   assign STATUS_FLAGS = status_word;

   // ALU result, written back on the same edge as the flags
   logic [7:0] result_q;
   logic [7:0] result_d;

   always_comb begin
      result_d = result_q;
      if (is_arith) begin
         result_d = sum[7:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= 8'h00;
      end else begin
         result_q <= result_d;
      end
   end

   assign ALU_RESULT = result_q;

   // RAM and read path
   sfm_ram_if #(.AW(RAM_AW)) ram_bus ();

   assign ram_bus.we = DATA_WE && ram_hit;
   assign ram_bus.addr = ram_addr;
   assign ram_bus.wdata = DATA_WDATA;

   sfm_ram #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
      .clk(CLK_SYS),
      .port(ram_bus.mem)
   );

   // Status read is registered so it answers in step with the RAM
   logic rd_ram_q;
   logic rd_ram_d;
   logic [7:0] rd_reg_q;
   logic [7:0] rd_reg_d;

   always_comb begin
      rd_ram_d = 1'b0;
      rd_reg_d = 8'h00;
      if (DATA_RE) begin
         rd_ram_d = ram_hit;
         if (status_hit) begin
            rd_reg_d = status_word;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rd_ram_q <= 1'b0;
         rd_reg_q <= 8'h00;
      end else begin
         rd_ram_q <= rd_ram_d;
         rd_reg_q <= rd_reg_d;
      end
   end

   // Unimplemented, peripheral and other core offsets read zero here
   assign DATA_RDATA = rd_ram_q ? ram_bus.rdata : rd_reg_q;
endmodule

// file: tb/sfm_core_data_chk.sv
// Port-level checks for the status flags and memory map block
`timescale 1ns/1ns
module sfm_core_data_chk (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic POR_RESET_N,
   input wire logic EXEC_VALID,
   input wire logic [4:0] EXEC_KIND,
   input wire logic [7:0] OPND_A,
   input wire logic [7:0] OPND_B,
   input wire logic [7:0] LOGIC_RESULT,
   input wire logic WATCHDOG_KICK_OP,
   input wire logic SLEEP_OP,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic [11:0] DATA_ADDR,
   input wire logic LINEAR_ACCESS,
   input wire logic DATA_WE,
   input wire logic DATA_RE,
   input wire logic [7:0] DATA_RDATA,
   input wire logic CORE_REG_HIT,
   input wire logic PERIPH_HIT,
   input wire logic [7:0] ALU_RESULT,
   input wire logic [7:0] STATUS_FLAGS
);
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N || !POR_RESET_N);
   wire [6:0] ofs = DATA_ADDR[6:0];
   wire is_add = EXEC_VALID && (EXEC_KIND == 5'h01 || EXEC_KIND == 5'h02);
   wire is_sub = EXEC_VALID && (EXEC_KIND == 5'h04 || EXEC_KIND == 5'h08);
   wire quiet = !EXEC_VALID && !WATCHDOG_KICK_OP && !SLEEP_OP && !WATCHDOG_TIMEOUT;
   wire [4:0] nib = {1'b0, OPND_A[3:0]} + {1'b0, OPND_B[3:0]};
   wire [4:0] nsb = {1'b0, OPND_A[3:0]} + {1'b0, ~OPND_B[3:0]} + 5'h01;
   wire [9:0] add_x = {nib[4], {1'b0, OPND_A} + {1'b0, OPND_B}};
   wire [9:0] sub_x = {nsb[4], {1'b0, OPND_A} + {1'b0, ~OPND_B} + 9'h001};
   wire [7:0] exp_sum = is_add ? add_x[7:0] : sub_x[7:0];
   sequence st_read;
      DATA_RE && !DATA_WE && !LINEAR_ACCESS && ofs == 7'h03 && quiet;
   endsequence
   hi_bits_a: assert property (STATUS_FLAGS[7:5] == 3'h0)
      else $error("upper status bits not zero");
   wdt_expiry_a: assert property (WATCHDOG_TIMEOUT |=> !STATUS_FLAGS[4])
      else $error("expiry flag not cleared");
   wdt_kick_a: assert property (WATCHDOG_KICK_OP && !SLEEP_OP && !WATCHDOG_TIMEOUT
      |=> STATUS_FLAGS[4:3] == 2'h3) else $error("kick did not set causes");
   sleep_entry_a: assert property (SLEEP_OP && !WATCHDOG_TIMEOUT
      |=> STATUS_FLAGS[4:3] == 2'h2) else $error("sleep causes wrong");
   add_carry_a: assert property (is_add
      |=> {STATUS_FLAGS[1:0], ALU_RESULT} == $past(add_x))
      else $error("add result or carries wrong");
   sub_borrow_a: assert property (is_sub
      |=> {STATUS_FLAGS[1:0], ALU_RESULT} == $past(sub_x))
      else $error("subtract result or borrows wrong");
   arith_zero_a: assert property (is_add || is_sub
      |=> STATUS_FLAGS[2] == ($past(exp_sum) == 8'h00))
      else $error("zero flag wrong after arithmetic");
   logic_zero_a: assert property (EXEC_VALID && EXEC_KIND == 5'h10
      |=> STATUS_FLAGS[2] == ($past(LOGIC_RESULT) == 8'h00) && $stable(STATUS_FLAGS[1:0]))
      else $error("logic op flags wrong");
   status_read_a: assert property (st_read |=> DATA_RDATA == STATUS_FLAGS)
      else $error("status read from bank wrong");
   cause_ro_a: assert property (DATA_WE && !LINEAR_ACCESS && ofs == 7'h03 && quiet
      |=> $stable(STATUS_FLAGS[4:3])) else $error("cause flags written");
   core_hit_a: assert property (CORE_REG_HIT == (!LINEAR_ACCESS && ofs <= 7'h0B))
      else $error("core decode wrong");
   periph_hit_a: assert property (!LINEAR_ACCESS
      |-> PERIPH_HIT == (ofs inside {[7'h0C:7'h1F]}))
      else $error("peripheral decode wrong");
endmodule
bind sfm_core_data sfm_core_data_chk u_chk (.*);

// file: tb/sfm_core_model.sv
// Core-side model issuing flag-affecting operations
`timescale 1ns/1ns
module sfm_core_model (
   input wire logic clk,
   output logic exec_valid,
   output logic [4:0] exec_kind,
   output logic [7:0] opnd_a,
   output logic [7:0] opnd_b,
   output logic [7:0] logic_res
);
   initial begin
      exec_valid = 1'b0;
      {exec_kind, opnd_a, opnd_b, logic_res} = 29'h0;
   end
   task automatic op(input logic [4:0] k, input logic [7:0] a, b, r);
      @(negedge clk);
      exec_valid = 1'b1;
      {exec_kind, opnd_a, opnd_b, logic_res} = {k, a, b, r};
      @(negedge clk);
      exec_valid = 1'b0;
      // Operands no longer qualified
      {opnd_a, opnd_b, logic_res} = ~{a, b, r};
   endtask
endmodule

// file: tb/test_sfm_core_data.sv
// Self-checking bench for the status flags and banked memory block
`timescale 1ns/1ns
module test_sfm_core_data;
   logic clk = 1'b0;
   logic rst_n, por_n, kick, slp, tmo, lin, we, re;
   logic [11:0] addr;
   logic [7:0] wd, rd, alu, st, oa, ob, lr;
   logic [4:0] kd;
   logic ev, chit, phit;
   int mismatches = 0;
   int n_checks = 0;
   // Rows: kind, a, b, logic result, sum, {Z,DC,C}
   logic [47:0] rows [9] = '{48'h01_0F_01_00_10_02, 48'h02_FF_01_00_00_07,
      48'h01_12_34_00_46_00, 48'h04_05_03_00_02_03, 48'h08_03_05_00_FE_00,
      48'h08_07_07_00_00_07, 48'h10_00_00_5A_00_03, 48'h10_00_00_00_00_07,
      48'h03_11_22_00_00_07};
   always #25 clk = ~clk;
   sfm_core_model u_core (.clk(clk), .exec_valid(ev), .exec_kind(kd), .opnd_a(oa),
      .opnd_b(ob), .logic_res(lr));
   sfm_core_data #(.GPR_BANKS(8)) u_dut (.CLK_SYS(clk), .RESET_N(rst_n),
      .POR_RESET_N(por_n), .EXEC_VALID(ev), .EXEC_KIND(kd), .OPND_A(oa), .OPND_B(ob),
      .LOGIC_RESULT(lr), .WATCHDOG_KICK_OP(kick), .SLEEP_OP(slp), .WATCHDOG_TIMEOUT(tmo),
      .DATA_ADDR(addr), .LINEAR_ACCESS(lin), .DATA_WE(we), .DATA_RE(re), .DATA_WDATA(wd),
      .DATA_RDATA(rd), .CORE_REG_HIT(chit), .PERIPH_HIT(phit), .ALU_RESULT(alu),
      .STATUS_FLAGS(st));
   task automatic chk(input string n, input logic [7:0] s, e);
      n_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic acc(input logic w, l, input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      {we, re, lin, addr, wd} = {w, ~w, l, a, d};
      @(negedge clk);
      {we, re, lin, addr, wd} = {3'h0, ~a, ~d};
   endtask
   task automatic evt(input logic [2:0] e, input logic [1:0] x);
      @(negedge clk);
      {kick, slp, tmo} = e;
      @(negedge clk);
      {kick, slp, tmo} = 3'h0;
      chk("causes", {6'h00, st[4:3]}, {6'h00, x});
   endtask
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
   initial begin
      {rst_n, por_n, kick, slp, tmo, lin, we, re} = 8'h00;
      {addr, wd} = 20'h0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      {rst_n, por_n} = 2'h3;
      repeat (3) @(negedge clk);
      chk("por", st, 8'h18);
      foreach (rows[i]) begin
         u_core.op(rows[i][44:40], rows[i][39:32], rows[i][31:24], rows[i][23:16]);
         chk("alu", alu, rows[i][15:8]);
         chk("flags", {5'h00, st[2:0]}, rows[i][7:0]);
      end
      evt(3'h1, 2'h1);
      evt(3'h4, 2'h3);
      evt(3'h2, 2'h2);
      evt(3'h5, 2'h1);
      evt(3'h6, 2'h2);
      acc(1'b1, 1'b0, 12'h083, 8'h00);
      chk("status write", st, 8'h10);
      fork
         u_core.op(5'h01, 8'h0F, 8'h01, 8'h00);
         acc(1'b1, 1'b0, 12'h003, 8'h00);
      join
      chk("write blocked", st, 8'h12);
      acc(1'b0, 1'b0, 12'hF83, 8'h00);
      chk("status far bank", rd, 8'h12);
      acc(1'b1, 1'b0, 12'h070, 8'hA5);
      acc(1'b0, 1'b0, 12'h3F0, 8'h00);
      chk("common", rd, 8'hA5);
      acc(1'b1, 1'b0, 12'h0A0, 8'h3C);
      acc(1'b0, 1'b1, 12'h050, 8'h00);
      chk("linear first", rd, 8'h3C);
      acc(1'b1, 1'b0, 12'h0EF, 8'hC3);
      acc(1'b0, 1'b1, 12'h09F, 8'h00);
      chk("bank end", rd, 8'hC3);
      acc(1'b1, 1'b1, 12'h27F, 8'h5E);
      acc(1'b0, 1'b0, 12'h3EF, 8'h00);
      chk("linear last", rd, 8'h5E);
      acc(1'b1, 1'b0, 12'h4A0, 8'h77);
      acc(1'b0, 1'b0, 12'h4A0, 8'h00);
      chk("unmapped", rd, 8'h00);
      acc(1'b0, 1'b0, 12'h18C, 8'h00);
      chk("periph", rd, 8'h00);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk("warm flags", st, 8'h12);
      chk("warm alu", alu, 8'h00);
      {rst_n, por_n} = 2'h0;
      repeat (2) @(negedge clk);
      {rst_n, por_n} = 2'h3;
      repeat (3) @(negedge clk);
      chk("por again", st, 8'h18);
      stop_test;
   end
endmodule
